/* File: verilog/cac_core.sv */
// Operation
// - count source: osc/12, osc/4, timer 0 overflow, external pin rise
// - with idle-stop set, counter holds while the processor idles
// - overflow with overflow irq enable set raises the interrupt request
// - watchdog enable turns on watchdog action of the compare module
// - counter runs only while run control is set; clearing halts it
// - hardware sets overflow flag on wrap; only software clears it
// - hardware sets module event flag on match or capture; software clears
// - module irq enable gates the event flag onto the interrupt request
// - modulation select with comparator enable makes the module pin a pulse width output
// - toggle bit inverts the module pin on each compare match
// - match-flag bit makes a compare match set the event flag
// - falling and rising capture enables; both set captures either edge
// - comparator enable turns on the module comparator
// - enabled pin transition copies the counter into the capture pair
// - comparator plus match-flag: equality flags event, irq if enabled
// - toggle, match-flag and comparator together give high-speed output
// - pwm output low while counter low byte below duty, else high
// - duty low byte reloads from high byte when counter low wraps
`timescale 1ns/1ns
`default_nettype none
module cac_core
  import cac_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire cac_pkg::cac_apb_req_t apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cpuIdle,
  input  wire logic                  timer0Ovf,
  input  wire logic                  externalCountInput,
  input  wire logic                  modulePinIn,
  output logic                       modulePinOut,
  output logic                       modulePinOe,
  output logic                       irqReq,
  output logic                       watchdogHit
);
  import cac_pkg::*;

  logic [7:0]  modeCnt_ff;
  logic        runCtl_ff;
  logic        ovfFlag_ff;
  logic        evtFlag_ff;
  logic [7:0]  modMode_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [7:0]  modLow_ff;
  logic [7:0]  modHigh_ff;
  logic [3:0]  pre_ff;
  logic        extPrev_ff;
  logic        pinPrev_ff;
  logic        pinOut_ff;
  logic        irq_ff;
  logic        wdog_ff;
  logic [31:0] rdata_ff;

  logic        setupPh;
  logic        srcTick;
  logic        tick;
  logic        ovfEv;
  logic        matchEv;
  logic        capEv;
  logic        pwmMode;
  logic        lowWrap;
  logic        known;

  function automatic logic riseOf(input logic prev, input logic cur);
    riseOf = cur & ~prev;
  endfunction

  function automatic logic hitAddr(input logic [7:0] a);
    hitAddr = (a == OFS_MODE_CNT) || (a == OFS_CTRL_FLAGS) ||
              (a == OFS_CNT_LOW) || (a == OFS_CNT_HIGH) ||
              (a == OFS_MOD_MODE) || (a == OFS_MOD_LOW) ||
              (a == OFS_MOD_HIGH);
  endfunction

  function automatic logic wrTo(input cac_apb_req_t r, input logic [7:0] a);
    wrTo = r.psel & r.penable & r.pwrite & (r.paddr == a);
  endfunction

  // bus: zero wait states, read data latched in the setup phase
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign known   = hitAddr(apbReq.paddr);
  assign pready  = apbReq.psel & apbReq.penable;
  assign pslverr = pready & ~known;
  assign prdata  = rdata_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 32'h0000_0000;
    else if (setupPh)
    begin
      case (apbReq.paddr)
        OFS_MODE_CNT:   rdata_ff <= {24'h00_0000, modeCnt_ff};
        OFS_CTRL_FLAGS: rdata_ff <= {24'h00_0000, ovfFlag_ff, runCtl_ff,
                                     1'b0, evtFlag_ff, 4'h0};
        OFS_CNT_LOW:    rdata_ff <= {24'h00_0000, cnt_ff[7:0]};
        OFS_CNT_HIGH:   rdata_ff <= {24'h00_0000, cnt_ff[15:8]};
        OFS_MOD_MODE:   rdata_ff <= {24'h00_0000, modMode_ff};
        OFS_MOD_LOW:    rdata_ff <= {24'h00_0000, modLow_ff};
        OFS_MOD_HIGH:   rdata_ff <= {24'h00_0000, modHigh_ff};
        default:        rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // counter mode register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      modeCnt_ff <= RST_BYTE;
    else if (wrTo(apbReq, OFS_MODE_CNT))
      modeCnt_ff <= apbReq.pwdata[7:0] & MASK_MODE_CNT;
  end

  // module mode register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      modMode_ff <= RST_BYTE;
    else if (wrTo(apbReq, OFS_MOD_MODE))
      modMode_ff <= apbReq.pwdata[7:0] & MASK_MOD_MODE;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      runCtl_ff <= 1'b0;
    else if (wrTo(apbReq, OFS_CTRL_FLAGS))
      runCtl_ff <= apbReq.pwdata[BIT_RUN];
  end

  // source ticks; prescaler free-runs so osc ticks stay evenly spaced
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_ff <= 4'h0;
    else if (pre_ff == PRE_LAST)
      pre_ff <= 4'h0;
    else
      pre_ff <= pre_ff + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extPrev_ff <= 1'b0;
      pinPrev_ff <= 1'b0;
    end
    else
    begin
      extPrev_ff <= externalCountInput;
      pinPrev_ff <= modulePinIn;
    end
  end

  always_comb
  begin
    case (modeCnt_ff[BIT_SRC_HI:BIT_SRC_LO])
      SRC_OSC12: srcTick = (pre_ff == PRE_LAST);
      SRC_OSC4:  srcTick = (pre_ff[1:0] == PRE_FAST_END);
      SRC_T0OVF: srcTick = timer0Ovf;
      SRC_EXT:   srcTick = riseOf(extPrev_ff, externalCountInput);
      default:   srcTick = 1'b0;
    endcase
  end

  assign tick = srcTick & runCtl_ff
              & ~(modeCnt_ff[BIT_IDLE_STOP] & cpuIdle);
  assign nxt_cnt = cnt_ff + 16'h0001;
  assign ovfEv   = tick & (cnt_ff == CNT_ALL_ONES);
  assign lowWrap = tick & (cnt_ff[7:0] == LOW_ALL_ONES);

  // counter; a software write to a byte beats a tick in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= 16'h0000;
    else
    begin
      if (tick)
        cnt_ff <= nxt_cnt;
      if (wrTo(apbReq, OFS_CNT_LOW))
        cnt_ff[7:0] <= apbReq.pwdata[7:0];
      if (wrTo(apbReq, OFS_CNT_HIGH))
        cnt_ff[15:8] <= apbReq.pwdata[7:0];
    end
  end

  // module decode
  assign pwmMode = modMode_ff[BIT_PWM_SEL]
                 & modMode_ff[BIT_CMP_EN];
  assign matchEv = tick & modMode_ff[BIT_CMP_EN] & ~pwmMode
                 & (nxt_cnt == {modHigh_ff, modLow_ff});
  assign capEv = (modMode_ff[BIT_RISE_CAP]
                  & riseOf(pinPrev_ff, modulePinIn))
               | (modMode_ff[BIT_FALL_CAP]
                  & riseOf(modulePinIn, pinPrev_ff));

  // capture pair; hardware capture and pwm reload beat software writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modLow_ff  <= RST_BYTE;
      modHigh_ff <= RST_BYTE;
    end
    else if (capEv)
    begin
      modLow_ff  <= cnt_ff[7:0];
      modHigh_ff <= cnt_ff[15:8];
    end
    else
    begin
      if (pwmMode && lowWrap)
        modLow_ff <= modHigh_ff;
      else if (wrTo(apbReq, OFS_MOD_LOW))
        modLow_ff <= apbReq.pwdata[7:0];
      if (wrTo(apbReq, OFS_MOD_HIGH))
        modHigh_ff <= apbReq.pwdata[7:0];
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovfFlag_ff <= 1'b0;
      evtFlag_ff <= 1'b0;
    end
    else
    begin
      if (ovfEv)
        ovfFlag_ff <= 1'b1;
      else if (wrTo(apbReq, OFS_CTRL_FLAGS))
        ovfFlag_ff <= apbReq.pwdata[BIT_OVF_FLAG];
      if (capEv || (matchEv && modMode_ff[BIT_MATCH_EN]))
        evtFlag_ff <= 1'b1;
      else if (wrTo(apbReq, OFS_CTRL_FLAGS))
        evtFlag_ff <= apbReq.pwdata[BIT_EVT_FLAG];
    end
  end

  // pin output: pwm level or toggle; registered so the pin never glitches
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pinOut_ff <= 1'b0;
    else if (pwmMode)
      pinOut_ff <= (cnt_ff[7:0] >= modLow_ff);
    else if (matchEv && modMode_ff[BIT_TOGGLE])
      pinOut_ff <= ~pinOut_ff;
  end

  assign modulePinOut = pinOut_ff;
  assign modulePinOe  = pwmMode | modMode_ff[BIT_TOGGLE];

  // interrupt request and watchdog hit
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ff  <= 1'b0;
      wdog_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= (ovfFlag_ff & modeCnt_ff[BIT_OVF_IRQ_EN])
              | (evtFlag_ff & modMode_ff[BIT_MOD_IRQ_EN]);
      // watchdog mode: match flag set, toggle clear
      wdog_ff <= modeCnt_ff[BIT_WDOG_EN] & matchEv
               & modMode_ff[BIT_MATCH_EN] & ~modMode_ff[BIT_TOGGLE];
    end
  end

  assign irqReq      = irq_ff;
  assign watchdogHit = wdog_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic noCntWr;
  assign noCntWr = ~wrTo(apbReq, OFS_CNT_LOW) & ~wrTo(apbReq, OFS_CNT_HIGH);

  logic noFlagWr;
  assign noFlagWr = ~wrTo(apbReq, OFS_CTRL_FLAGS);

  sequence s_extEdge;
    modeCnt_ff[BIT_SRC_HI:BIT_SRC_LO] == SRC_EXT && runCtl_ff && !cpuIdle
      && !extPrev_ff && externalCountInput && noCntWr;
  endsequence

  sequence s_capEdge;
    modMode_ff[BIT_RISE_CAP] && !pinPrev_ff && modulePinIn;
  endsequence

  a_ext_src_step: assert property (
    s_extEdge |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("external edge did not advance counter");

  a_idle_stop_hold: assert property (
    (modeCnt_ff[BIT_IDLE_STOP] && cpuIdle && noCntWr) |=> $stable(cnt_ff))
    else $error("counter moved in idle with idle-stop");

  a_halt_hold: assert property (
    (!runCtl_ff && noCntWr) |=> $stable(cnt_ff))
    else $error("counter moved while halted");

  a_ovf_flag_set: assert property (
    (tick && cnt_ff == CNT_ALL_ONES && noCntWr)
      |=> ovfFlag_ff && cnt_ff == 16'h0000)
    else $error("wrap did not set overflow flag");

  a_ovf_irq_out: assert property (
    (ovfFlag_ff && modeCnt_ff[BIT_OVF_IRQ_EN]) |=> irqReq)
    else $error("overflow irq missing");

  a_evt_irq_gate: assert property (
    (!ovfFlag_ff && evtFlag_ff && !modMode_ff[BIT_MOD_IRQ_EN]) |=> !irqReq)
    else $error("event irq not gated");

  a_capture_load: assert property (
    s_capEdge |=> evtFlag_ff && {modHigh_ff, modLow_ff} == $past(cnt_ff))
    else $error("capture did not load counter");

  a_match_toggle: assert property (
    (matchEv && modMode_ff[BIT_TOGGLE])
      |=> modulePinOut != $past(modulePinOut))
    else $error("match did not toggle pin");

  a_match_flag: assert property (
    (matchEv && modMode_ff[BIT_MATCH_EN]) |=> evtFlag_ff)
    else $error("match did not set event flag");

  a_duty_reload: assert property (
    (pwmMode && lowWrap && !capEv) |=> modLow_ff == $past(modHigh_ff))
    else $error("duty byte not reloaded");

  a_pwm_level: assert property (
    (pwmMode && cnt_ff[7:0] < modLow_ff) ##1 pwmMode |-> !modulePinOut)
    else $error("pwm output high below duty");

  a_pwm_high: assert property (
    (pwmMode && cnt_ff[7:0] >= modLow_ff) ##1 pwmMode |-> modulePinOut)
    else $error("pwm output low at or above duty");

  a_t0_src_step: assert property (
    (modeCnt_ff[BIT_SRC_HI:BIT_SRC_LO] == SRC_T0OVF && runCtl_ff
      && !cpuIdle && timer0Ovf && noCntWr)
      |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("timer 0 overflow did not advance counter");

  // flags only fall on a software write
  a_ovf_flag_hold: assert property (
    (ovfFlag_ff && noFlagWr) |=> ovfFlag_ff)
    else $error("overflow flag cleared without a write");

  a_evt_flag_hold: assert property (
    (evtFlag_ff && noFlagWr) |=> evtFlag_ff)
    else $error("event flag cleared without a write");

  a_evt_irq_out: assert property (
    (evtFlag_ff && modMode_ff[BIT_MOD_IRQ_EN]) |=> irqReq)
    else $error("event irq missing");

  a_cap_fall: assert property (
    (modMode_ff[BIT_FALL_CAP] && pinPrev_ff && !modulePinIn)
      |=> {modHigh_ff, modLow_ff} == $past(cnt_ff))
    else $error("falling edge did not capture counter");

endmodule // cac_core
`default_nettype wire

/* File: verilog/cac_pkg.sv */
`default_nettype none
package cac_pkg;

  // bus-side request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cac_apb_req_t;

  // register byte offsets
  localparam logic [7:0] OFS_MODE_CNT   = 8'h00;
  localparam logic [7:0] OFS_CTRL_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW    = 8'h08;
  localparam logic [7:0] OFS_CNT_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_MOD_MODE   = 8'h10;
  localparam logic [7:0] OFS_MOD_LOW    = 8'h14;
  localparam logic [7:0] OFS_MOD_HIGH   = 8'h18;

  // counter mode register fields
  localparam int BIT_OVF_IRQ_EN  = 0;
  localparam int BIT_SRC_LO      = 1;
  localparam int BIT_SRC_HI      = 2;
  localparam int BIT_WDOG_EN     = 6;
  localparam int BIT_IDLE_STOP   = 7;

  // control/flag register fields
  localparam int BIT_EVT_FLAG    = 4;
  localparam int BIT_RUN         = 6;
  localparam int BIT_OVF_FLAG    = 7;

  // module mode register fields
  localparam int BIT_MOD_IRQ_EN  = 0;
  localparam int BIT_PWM_SEL     = 1;
  localparam int BIT_TOGGLE      = 2;
  localparam int BIT_MATCH_EN    = 3;
  localparam int BIT_FALL_CAP    = 4;
  localparam int BIT_RISE_CAP    = 5;
  localparam int BIT_CMP_EN      = 6;

  // writable bit masks and reset values
  localparam logic [7:0] MASK_MODE_CNT   = 8'hC7;
  localparam logic [7:0] MASK_CTRL_FLAGS = 8'hD0;
  localparam logic [7:0] MASK_MOD_MODE   = 8'h7F;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // count sources
  localparam logic [1:0] SRC_OSC12 = 2'h0;
  localparam logic [1:0] SRC_OSC4  = 2'h1;
  localparam logic [1:0] SRC_T0OVF = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;

  // prescaler: one shared modulo-12 count also yields the /4 tick
  localparam int         OSC_DIV_SLOW = 12;
  localparam int         OSC_DIV_FAST = 4;
  localparam logic [3:0] PRE_LAST     = 4'(OSC_DIV_SLOW - 1);
  localparam logic [1:0] PRE_FAST_END = 2'(OSC_DIV_FAST - 1);

  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [7:0]  LOW_ALL_ONES = 8'hFF;

endpackage
`default_nettype wire

/* File: bench/cac_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cac_pin_model (
  input  wire logic modulePinOut,
  input  wire logic modulePinOe,
  input  wire logic drivenLevel,
  output logic      modulePinIn
);
  // pin reads its own drive while the module owns it, else the far level
  assign modulePinIn = modulePinOe ? modulePinOut : drivenLevel;
endmodule // cac_pin_model
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cac_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  cac_apb_req_t apbReq = '0;
  logic [31:0]  prdata;
  logic         pready, pslverr, modulePinIn, modulePinOut, modulePinOe;
  logic         irqReq, watchdogHit, level = 1'b0, wdSeen = 1'b0;
  logic         cpuIdle = 1'b0, timer0Ovf = 1'b0, externalCountInput = 1'b0;
  logic [7:0]   rd;
  logic         err, pin0;
  int           num_errors = 0;
  int           checks_done = 0;
  logic [7:0]   ofsTab [3] = '{OFS_MODE_CNT, OFS_CTRL_FLAGS, OFS_MOD_MODE};
  logic [7:0]   maskTab [3] = '{MASK_MODE_CNT, MASK_CTRL_FLAGS, MASK_MOD_MODE};
  always #10 sys_clk = ~sys_clk;
  // pulse output is short, so keep a sticky copy
  always @(posedge sys_clk) if (watchdogHit === 1'b1) wdSeen <= 1'b1;
  cac_core u_cac_core (.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle),
    .timer0Ovf(timer0Ovf), .externalCountInput(externalCountInput),
    .modulePinIn(modulePinIn), .modulePinOut(modulePinOut),
    .modulePinOe(modulePinOe), .irqReq(irqReq), .watchdogHit(watchdogHit));
  cac_pin_model u_cac_pin_model (.modulePinOut(modulePinOut),
    .modulePinOe(modulePinOe), .drivenLevel(level),
    .modulePinIn(modulePinIn));
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("Error at %0t got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // entered just after a rising edge; waits on pready, no fixed latency
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    apbReq <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    if (n >= 50) num_errors++;
    // one idle edge so the next call never re-drives psel in this step
    apbReq <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic setCnt(input logic [7:0] hi, input logic [7:0] lo);
    xfer(1'b1, OFS_CNT_HIGH, hi);
    xfer(1'b1, OFS_CNT_LOW, lo);
  endtask
  task automatic startCnt(input logic [7:0] modeCnt);
    setCnt(8'h00, 8'h00);
    xfer(1'b1, OFS_MODE_CNT, modeCnt);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h40);
  endtask
  // stop, then read the low byte
  task automatic stopChk(input logic [7:0] e);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    rchk(OFS_CNT_LOW, e);
  endtask
  task automatic matchRun(input logic [7:0] modeCnt, input logic [7:0] mm);
    xfer(1'b1, OFS_MOD_LOW, 8'h05);
    xfer(1'b1, OFS_MOD_HIGH, 8'h00);
    xfer(1'b1, OFS_MOD_MODE, mm);
    startCnt(modeCnt);
    // match is several ticks away, so the pin is still pre-match here
    pin0 = modulePinOut;
    cyc(40);
  endtask
  initial
  begin
    #200_000;
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), RST_BYTE);
    xfer(1'b0, 8'h1C, 8'h00);
    chk({7'h0, err}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, ofsTab[i], 8'hFF);
      rchk(ofsTab[i], maskTab[i]);
      xfer(1'b1, ofsTab[i], 8'h00);
    end
    startCnt(8'h00);
    cyc(117);
    stopChk(8'h0A);
    startCnt(8'h02);
    cyc(117);
    stopChk(8'h1E);
    startCnt(8'h04);
    repeat (5)
    begin
      timer0Ovf <= 1'b1;
      cyc(1);
      timer0Ovf <= 1'b0;
      cyc(2);
    end
    stopChk(8'h05);
    startCnt(8'h06);
    repeat (6)
    begin
      externalCountInput <= ~externalCountInput;
      cyc(2);
    end
    stopChk(8'h03);
    cpuIdle <= 1'b1;
    startCnt(8'h82);
    cyc(60);
    stopChk(8'h00);
    cpuIdle <= 1'b0;
    xfer(1'b1, OFS_MODE_CNT, 8'h03);
    setCnt(8'hFF, 8'hFC);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h40);
    cyc(40);
    chk({7'h0, irqReq}, 8'h01);
    rchk(OFS_CTRL_FLAGS, 8'hC0);
    cyc(30);
    rchk(OFS_CTRL_FLAGS, 8'hC0);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    rchk(OFS_CTRL_FLAGS, 8'h00);
    rchk(OFS_CNT_HIGH, 8'h00);
    setCnt(8'h12, 8'h34);
    xfer(1'b1, OFS_MOD_MODE, 8'h20);
    level <= 1'b1;
    cyc(3);
    rchk(OFS_MOD_LOW, 8'h34);
    rchk(OFS_MOD_HIGH, 8'h12);
    rchk(OFS_CTRL_FLAGS, 8'h10);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    xfer(1'b1, OFS_MOD_MODE, 8'h10);
    xfer(1'b1, OFS_CNT_LOW, 8'h56);
    level <= 1'b0;
    cyc(3);
    xfer(1'b1, OFS_CNT_LOW, 8'h78);
    level <= 1'b1;
    cyc(3);
    rchk(OFS_MOD_LOW, 8'h56);
    xfer(1'b1, OFS_MOD_MODE, 8'h30);
    xfer(1'b1, OFS_CNT_LOW, 8'h9A);
    level <= 1'b0;
    cyc(3);
    rchk(OFS_MOD_LOW, 8'h9A);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    matchRun(8'h02, 8'h4C);
    chk({modulePinOe, modulePinOut}, {1'b1, ~pin0});
    rchk(OFS_CTRL_FLAGS, 8'h50);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    matchRun(8'h42, 8'h49);
    chk({6'h0, wdSeen, irqReq}, 8'h03);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    cyc(3);
    chk({7'h0, irqReq}, 8'h00);
    xfer(1'b1, OFS_MOD_LOW, 8'h80);
    xfer(1'b1, OFS_MOD_HIGH, 8'h20);
    xfer(1'b1, OFS_MOD_MODE, 8'h42);
    xfer(1'b1, OFS_CNT_LOW, 8'h10);
    cyc(3);
    chk({6'h0, modulePinOe, modulePinOut}, 8'h02);
    xfer(1'b1, OFS_CNT_LOW, 8'h90);
    cyc(3);
    chk({7'h0, modulePinOut}, 8'h01);
    xfer(1'b1, OFS_CNT_LOW, 8'hFF);
    xfer(1'b1, OFS_MODE_CNT, 8'h06);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h40);
    externalCountInput <= 1'b1;
    cyc(3);
    xfer(1'b1, OFS_CTRL_FLAGS, 8'h00);
    xfer(1'b1, OFS_CNT_LOW, 8'h1F);
    cyc(3);
    chk({7'h0, modulePinOut}, 8'h00);
    xfer(1'b1, OFS_CNT_LOW, 8'h20);
    cyc(3);
    chk({7'h0, modulePinOut}, 8'h01);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
